// ==== verilog/pse_mode_ctrl.sv ====
/*
  channel operating-mode control for four channels (two ports) with the
  register set that the modes touch, and one sequencer per channel.
  assumes a command-port front end that presents decoded register
  writes and reads on the system clock, and an analog measurement engine.
*/
// Overview of operation
// - two-bit mode per channel, reset zero: off, manual, semiauto, auto.
// - four-pair port channels need equal modes, else turn-on is ignored.
// - off mode keeps channel unpowered, no detection or classification.
// - entering off clears flags, faults, class, power status, enables, foldback.
// - entering off loads two-pair policing, and four-pair policing on four-pair ports, with all ones.
// - entering off clears measurements, resistance, classes and autoclass results.
// - clearing may take up to 5 ms; host waits before relying on it.
// - off clearing touches only bits of that channel or port.
// - power-good or power-enabled falling sets its change event.
// - semiauto to manual or off aborts a running cooldown.
// - manual mode idles until commanded, then runs one cycle.
// - power-on command turns the channel on at once, no discovery.
// - manual-powered channels get no class; host programs policing, foldback.
// - manual four-pair, one channel enabled: run it alone, no connection check.
// - manual four-pair, both detects in one write: detect both, check if valid.
// - manual four-pair, both class enables in one write: staggered classification.
// - manual four-pair disconnect is per channel, sets disconnect fault.
// - semiauto unpowered: idle, cycle detect, or cycle detect plus class.
// - semiauto four-pair: connection check once either channel detects valid.
// - unpowered half of dual-signature load resumes discovery if enabled.
// - auto powers valid, classified channels; idle until enabled or commanded.
// - manual detect and class enables clear themselves after their cycle.
// - four-pair semiauto or auto needs both enables on both channels.
`timescale 1ns/1ns
module pse_mode_ctrl #(
  parameter int DROPOUT_CYC = pse_mode_pkg::DROPOUT_CYC,
  parameter int COOL_CYC    = pse_mode_pkg::COOL_CYC
) (
  input  wire logic        clk_in,         // system clock
  input  wire logic        sys_rst_in,     // async reset, high
  input  wire logic        ce_in,          // clock enable
  input  wire logic        reg_wr_in,      // register write strobe
  input  wire logic        reg_rd_in,      // register read strobe
  input  wire logic [7:0]  reg_cmd_in,     // command code
  input  wire logic [7:0]  reg_wdata_in,   // write data
  output logic [7:0]       reg_rdata_out,  // read data
  input  wire logic [3:0]  meas_done_in,   // measurement finished
  input  wire logic [3:0]  det_valid_in,   // detection result valid
  input  wire logic [3:0]  pg_pin_in,      // power-good comparator pin
  input  wire logic [3:0]  low_cur_pin_in, // below hold current pin
  input  wire logic [3:0]  cut_fault_in,   // overpower cut pulse
  input  wire logic [3:0]  start_fault_in, // startup fault pulse
  input  wire logic [3:0]  ilim_fault_in,  // current limit pulse
  output logic [3:0]       det_start_out,  // start detection
  output logic [3:0]       cls_start_out,  // start classification
  output logic [1:0]       conn_start_out, // start connection check
  output logic [3:0]       power_en_out,   // channel switch on
  output logic [3:0]       clear_meas_out, // wipe measurement store
  output logic [31:0]      police2_out,    // two-pair policing
  output logic [15:0]      police4_out,    // four-pair policing
  output logic [3:0]       foldback_out    // double_foldback_select
);
  import pse_mode_pkg::*;

  typedef struct packed {
    logic [7:0]      mode;
    logic [7:0]      prev_mode;
    logic [7:0]      en;
    logic [7:0]      evt;
    logic [7:0]      cmp;
    logic [7:0]      flt;
    logic [7:0]      sil;
    logic [3:0][7:0] pol2;
    logic [1:0][7:0] pol4;
    logic [3:0]      fb;
    logic [1:0]      fpw;
    logic [7:0]      rdata;
    logic [3:0]      last_pwr;
    logic [3:0]      last_pg;
    logic [1:0]      both_det;
    logic [1:0]      stagger;
    logic [3:0]      pd_done;
    logic [3:0]      pd_ok;
    logic [1:0]      conn;
    logic [3:0]      clr;
    logic [7:0]      s1;
    logic [7:0]      s2;
    logic [7:0]      s3;
    logic [7:0]      f;
  } top_s;

  localparam top_s RESET_S = '{mode: MODE_RESET, pol2: {4{POLICE_RESET}},
                               pol4: {2{POLICE_RESET}}, default: '0};

  top_s       s;
  top_s       next_s;
  ch_ctl_s    ctl   [NUM_CH];
  ch_ana_s    ana   [NUM_CH];
  ch_out_s    chout [NUM_CH];
  logic [3:0] power_on_command_cmd;
  logic [3:0] pwr;
  logic [3:0] pg;
  logic [3:0] port_ok;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel sequencers

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    localparam int P = g / 2;
    localparam int A = 2 * P;
    assign power_on_command_cmd[g] = reg_wr_in && reg_cmd_in == CMD_POWER_ON_COMMAND && reg_wdata_in[g];
    assign port_ok[g] = !s.fpw[P] || s.mode[4*P +: 2] == s.mode[4*P+2 +: 2];
    assign ctl[g] = '{mode: s.mode[2*g +: 2], det_en: s.en[g], cls_en: s.en[4+g],
                      power_on_command: power_on_command_cmd[g], port_ok: port_ok[g],
                      pair_go: &{s.en[A], s.en[A+1], s.en[4+A], s.en[5+A]},
                      cls_block: (g % 2 == 1) && s.stagger[P] && s.en[4+A],
                      four_pair: s.fpw[P]};
    assign ana[g] = '{meas_done: meas_done_in[g], det_valid: det_valid_in[g],
                      pg: s.f[4+g], low_cur: s.f[g],
                      fault: cut_fault_in[g] | start_fault_in[g] | ilim_fault_in[g]};
    pse_channel_seq #(
      .DROPOUT_CYC (DROPOUT_CYC),
      .COOL_CYC    (COOL_CYC)
    ) u_seq (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .ctl_in     (ctl[g]),
      .ana_in     (ana[g]),
      .out_out    (chout[g])
    );
    assign pwr[g] = chout[g].pwr;
    assign pg[g] = chout[g].pg;
    assign det_start_out[g] = chout[g].det_start;
    assign cls_start_out[g] = chout[g].cls_start;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and mode-change side effects

  always_comb begin
    next_s = s;
    next_s.prev_mode = s.mode;
    next_s.conn = '0;
    next_s.clr = '0;
    next_s.last_pwr = pwr;
    next_s.last_pg = pg;
    // pins: a change counts once stages two and three agree
    next_s.s1 = {pg_pin_in, low_cur_pin_in};
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int b = 0; b < 8; b++) begin
      if (s.s2[b] == s.s3[b]) next_s.f[b] = s.s3[b];
    end
    // hardware clears first so a write in the same cycle wins
    for (int i = 0; i < NUM_CH; i++) begin
      if (chout[i].clr_det) next_s.en[i] = 1'b0;
      if (chout[i].clr_cls) next_s.en[4+i] = 1'b0;
      if (s.mode[2*i +: 2] == MODE_OFF && s.prev_mode[2*i +: 2] != MODE_OFF) begin
        next_s.en[i] = 1'b0;
        next_s.en[4+i] = 1'b0;
        next_s.cmp[i] = 1'b0;
        next_s.cmp[4+i] = 1'b0;
        next_s.flt[i] = 1'b0;
        next_s.flt[4+i] = 1'b0;
        next_s.sil[i] = 1'b0;
        next_s.sil[4+i] = 1'b0;
        next_s.fb[i] = 1'b0;
        next_s.pol2[i] = POLICE_RESET;
        if (s.fpw[i/2]) next_s.pol4[i/2] = POLICE_RESET;
        next_s.clr[i] = 1'b1;
      end
    end
    for (int p = 0; p < NUM_PRT; p++) begin
      if (!s.en[4+2*p] && !s.en[5+2*p]) next_s.stagger[p] = 1'b0;
    end
    if (reg_wr_in) begin
      if (reg_cmd_in >= CMD_POL2 && reg_cmd_in <= CMD_POL2 + 8'h03) begin
        next_s.pol2[reg_cmd_in[1:0] - CMD_POL2[1:0]] = reg_wdata_in;
      end
      if (reg_cmd_in[7:1] == CMD_POL4[7:1]) next_s.pol4[reg_cmd_in[0]] = reg_wdata_in;
      case (reg_cmd_in)
        CMD_MODE:   next_s.mode = reg_wdata_in;
        CMD_ENABLE: begin
          next_s.en = reg_wdata_in;
          for (int p = 0; p < NUM_PRT; p++) begin
            if (s.fpw[p] && s.mode[4*p +: 4] == {MODE_MAN, MODE_MAN}) begin
              if (reg_wdata_in[2*p] && reg_wdata_in[2*p+1]) begin
                next_s.both_det[p] = 1'b1;
                next_s.pd_done[2*p +: 2] = 2'h0;
                next_s.pd_ok[2*p +: 2] = 2'h0;
              end
              if (reg_wdata_in[4+2*p] && reg_wdata_in[5+2*p]) next_s.stagger[p] = 1'b1;
            end
          end
        end
        CMD_EVENT:  next_s.evt = s.evt & ~reg_wdata_in;
        CMD_DETCLS: next_s.cmp = s.cmp & ~reg_wdata_in;
        CMD_FAULT:  next_s.flt = s.flt & ~reg_wdata_in;
        CMD_STILIM: next_s.sil = s.sil & ~reg_wdata_in;
        CMD_FPW:    next_s.fpw = reg_wdata_in[1:0];
        CMD_FB:     next_s.fb = reg_wdata_in[3:0];
        default:    next_s.mode = s.mode;
      endcase
    end
    // hardware sets last so an event never loses to a clear
    for (int i = 0; i < NUM_CH; i++) begin
      if (s.last_pwr[i] && !pwr[i]) next_s.evt[i] = 1'b1;
      if (s.last_pg[i] && !pg[i]) next_s.evt[4+i] = 1'b1;
      if (chout[i].det_fin) next_s.cmp[i] = 1'b1;
      if (chout[i].cls_fin) next_s.cmp[4+i] = 1'b1;
      if (cut_fault_in[i]) next_s.flt[i] = 1'b1;
      if (chout[i].disc) next_s.flt[4+i] = 1'b1;
      if (ilim_fault_in[i]) next_s.sil[i] = 1'b1;
      if (start_fault_in[i]) next_s.sil[4+i] = 1'b1;
    end
    for (int p = 0; p < NUM_PRT; p++) begin
      if (s.fpw[p] && s.mode[4*p+1]) begin
        if ((chout[2*p].det_fin && chout[2*p].det_ok) ||
            (chout[2*p+1].det_fin && chout[2*p+1].det_ok)) next_s.conn[p] = 1'b1;
      end
      // single-channel manual detects never reach here, so no check runs
      if (s.both_det[p]) begin
        for (int k = 2*p; k < 2*p+2; k++) begin
          if (chout[k].det_fin) next_s.pd_done[k] = 1'b1;
          if (chout[k].det_fin && chout[k].det_ok) next_s.pd_ok[k] = 1'b1;
        end
        if (&next_s.pd_done[2*p +: 2]) begin
          next_s.conn[p] = &next_s.pd_ok[2*p +: 2];
          next_s.both_det[p] = 1'b0;
        end
      end
    end
    if (reg_rd_in) begin
      if (reg_cmd_in >= CMD_POL2 && reg_cmd_in <= CMD_POL2 + 8'h03) begin
        next_s.rdata = s.pol2[reg_cmd_in[1:0] - CMD_POL2[1:0]];
      end else if (reg_cmd_in[7:1] == CMD_POL4[7:1]) begin
        next_s.rdata = s.pol4[reg_cmd_in[0]];
      end else begin
        case (reg_cmd_in)
          CMD_MODE:   next_s.rdata = s.mode;
          CMD_ENABLE: next_s.rdata = s.en;
          CMD_EVENT:  next_s.rdata = s.evt;
          CMD_DETCLS: next_s.rdata = s.cmp;
          CMD_FAULT:  next_s.rdata = s.flt;
          CMD_STILIM: next_s.rdata = s.sil;
          CMD_STATUS: next_s.rdata = {pg, pwr};
          CMD_FPW:    next_s.rdata = {6'h00, s.fpw};
          CMD_FB:     next_s.rdata = {4'h0, s.fb};
          default:    next_s.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= RESET_S;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign reg_rdata_out = s.rdata;
  assign conn_start_out = s.conn;
  assign power_en_out = pwr;
  assign clear_meas_out = s.clr;
  assign police2_out = s.pol2;
  assign police4_out = s.pol4;
  assign foldback_out = s.fb;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  logic off_entry0;
  assign off_entry0 = ce_in && s.mode[1:0] == MODE_OFF && s.prev_mode[1:0] != MODE_OFF;

  a_mode_write: assert property (
    (ce_in && reg_wr_in && reg_cmd_in == CMD_MODE) |=> s.mode == $past(reg_wdata_in))
    else $error("mode register did not take the written value");

  a_pair_mismatch: assert property (
    (ce_in && power_on_command_cmd[0] && !port_ok[0] && !power_en_out[0] && s.mode[1:0] != MODE_AUTO)
    |=> !power_en_out[0])
    else $error("turn-on accepted on a port with unequal modes");

  a_off_unpowered: assert property (
    (ce_in && s.mode[1:0] == MODE_OFF) ##1 (ce_in && s.mode[1:0] == MODE_OFF)
    |=> !power_en_out[0] && !det_start_out[0] && !cls_start_out[0])
    else $error("off channel powered or discovering");

  a_off_clear: assert property (
    (off_entry0 && !reg_wr_in) |=> !s.en[0] && !s.en[4] && !s.fb[0])
    else $error("off entry left enables or foldback set");

  a_off_police: assert property (
    (off_entry0 && !reg_wr_in) |=> s.pol2[0] == POLICE_RESET)
    else $error("off entry did not load policing with ones");

  a_off_meas: assert property (
    off_entry0 |=> clear_meas_out[0] ##1 (!clear_meas_out[0] || !$past(ce_in)))
    else $error("measurement wipe not a single pulse on off entry");

  a_other_kept: assert property (
    (off_entry0 && !reg_wr_in && s.mode[3:2] == s.prev_mode[3:2])
    |=> s.pol2[1] == $past(s.pol2[1]) && !clear_meas_out[1])
    else $error("off entry disturbed a neighbouring channel");

  a_pe_event: assert property (
    (ce_in && $fell(power_en_out[0])) |=> s.evt[0])
    else $error("power-enable change event missing");

  a_power_on_command_now: assert property (
    (ce_in && power_on_command_cmd[0] && port_ok[0] && s.mode[1:0] != MODE_OFF)
    |=> power_en_out[0] && !det_start_out[0])
    else $error("power-on command did not switch on at once");

  c_auto_power: cover property (s.mode[1:0] == MODE_AUTO && $rose(power_en_out[0]));
  c_conn_check: cover property (conn_start_out[0]);
  c_off_entry: cover property (off_entry0 && s.last_pwr[0]);
endmodule

// ==== verilog/pse_mode_pkg.sv ====
/*
  constants, encodings and carriers shared by the channel mode control block.
  assumes a single 250 mhz system clock.
*/
package pse_mode_pkg;
  localparam int NUM_CH  = 4;
  localparam int NUM_PRT = 2;
  // channel_mode_bits encodings
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_MAN  = 2'h1;
  localparam logic [1:0] MODE_SEMI = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  // command codes
  localparam logic [7:0] CMD_EVENT  = 8'h02;
  localparam logic [7:0] CMD_DETCLS = 8'h04;
  localparam logic [7:0] CMD_FAULT  = 8'h06;
  localparam logic [7:0] CMD_STILIM = 8'h08;
  localparam logic [7:0] CMD_STATUS = 8'h10;
  localparam logic [7:0] CMD_MODE   = 8'h12;
  localparam logic [7:0] CMD_ENABLE = 8'h14;
  localparam logic [7:0] CMD_POWER_ON_COMMAND   = 8'h19;
  localparam logic [7:0] CMD_POL2   = 8'h1e;
  localparam logic [7:0] CMD_FPW    = 8'h29;
  localparam logic [7:0] CMD_POL4   = 8'h2a;
  localparam logic [7:0] CMD_FB     = 8'h40;
  // values after reset
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] POLICE_RESET = 8'hff;
  // timing
  localparam int CLK_MHZ         = 250;
  localparam int HOLD_DROPOUT_US = 400;
  localparam int COOLDOWN_MS     = 1000;
  localparam int DROPOUT_CYC     = HOLD_DROPOUT_US * CLK_MHZ;
  localparam int COOL_CYC        = COOLDOWN_MS * 1000 * CLK_MHZ;
  localparam int CNT_W           = 28;

  typedef enum logic [2:0] {CH_IDLE, CH_DETECT, CH_CLASSIFY, CH_POWERED, CH_COOL} ch_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       det_en;
    logic       cls_en;
    logic       power_on_command;
    logic       port_ok;
    logic       pair_go;
    logic       cls_block;
    logic       four_pair;
  } ch_ctl_s;

  typedef struct packed {
    logic meas_done;
    logic det_valid;
    logic pg;
    logic low_cur;
    logic fault;
  } ch_ana_s;

  typedef struct packed {
    logic pwr;
    logic pg;
    logic det_ok;
    logic det_start;
    logic cls_start;
    logic det_fin;
    logic cls_fin;
    logic disc;
    logic clr_det;
    logic clr_cls;
  } ch_out_s;
endpackage

// ==== verilog/pse_channel_seq.sv ====
/*
  per-channel discovery and power sequencer.
  assumes mode, enables and commands from the register block on the same clock.
*/
`timescale 1ns/1ns
module pse_channel_seq #(
  parameter int DROPOUT_CYC = 1,
  parameter int COOL_CYC    = 1
) (
  input  wire logic                  clk_in,     // system clock
  input  wire logic                  sys_rst_in, // async reset, high
  input  wire logic                  ce_in,      // clock enable
  input  wire pse_mode_pkg::ch_ctl_s ctl_in,     // mode and commands
  input  wire pse_mode_pkg::ch_ana_s ana_in,     // measurement results
  output pse_mode_pkg::ch_out_s      out_out     // requests and flags
);
  import pse_mode_pkg::*;

  typedef struct packed {
    ch_state_e        st;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       last_mode;
    logic             used_det;
    logic             used_cls;
    ch_out_s          o;
  } seq_s;

  seq_s s;
  seq_s next_s;
  logic manual;

  assign manual = ctl_in.mode == MODE_MAN;

  always_comb begin
    next_s = s;
    next_s.last_mode = ctl_in.mode;
    next_s.o = '{pwr: s.o.pwr, pg: s.o.pg, det_ok: s.o.det_ok, default: 1'b0};
    // one-shot latches rearm only once the enable bit is clear again
    if (!ctl_in.det_en) next_s.used_det = 1'b0;
    if (!ctl_in.cls_en) next_s.used_cls = 1'b0;
    if (ctl_in.mode == MODE_OFF) begin
      next_s.st = CH_IDLE;
      next_s.o.pwr = 1'b0;
      next_s.o.pg = 1'b0;
      next_s.o.det_ok = 1'b0;
      next_s.cnt = '0;
    end else if (ctl_in.power_on_command && ctl_in.port_ok) begin
      next_s.st = CH_POWERED;
      next_s.o.pwr = 1'b1;
      next_s.cnt = '0;
    end else if (s.st == CH_COOL && s.last_mode == MODE_SEMI && manual) begin
      next_s.st = CH_IDLE;
      next_s.cnt = '0;
    end else begin
      unique case (s.st)
        CH_IDLE: begin
          if (manual && ctl_in.det_en && !s.used_det) begin
            next_s.st = CH_DETECT;
            next_s.used_det = 1'b1;
            next_s.o.det_start = 1'b1;
          end else if (manual && ctl_in.cls_en && !s.used_cls && !ctl_in.cls_block) begin
            next_s.st = CH_CLASSIFY;
            next_s.used_cls = 1'b1;
            next_s.o.cls_start = 1'b1;
          end else if (!manual && ctl_in.det_en && (!ctl_in.four_pair || ctl_in.pair_go)) begin
            next_s.st = CH_DETECT;
            next_s.o.det_start = 1'b1;
          end
        end
        CH_DETECT: begin
          if (ana_in.meas_done) begin
            next_s.o.det_fin = 1'b1;
            next_s.o.det_ok = ana_in.det_valid;
            next_s.o.clr_det = manual;
            if (!manual && ctl_in.cls_en && ana_in.det_valid) begin
              next_s.st = CH_CLASSIFY;
              next_s.o.cls_start = 1'b1;
            end else begin
              next_s.st = CH_IDLE;
            end
          end
        end
        CH_CLASSIFY: begin
          if (ana_in.meas_done) begin
            next_s.o.cls_fin = 1'b1;
            next_s.o.clr_cls = manual;
            if (ctl_in.mode == MODE_AUTO && ctl_in.port_ok) begin
              next_s.st = CH_POWERED;
              next_s.o.pwr = 1'b1;
              next_s.cnt = '0;
            end else begin
              next_s.st = CH_IDLE;
            end
          end
        end
        CH_POWERED: begin
          next_s.o.pg = s.o.pg | ana_in.pg;
          if (ana_in.fault) begin
            next_s.st = CH_COOL;
            next_s.o.pwr = 1'b0;
            next_s.o.pg = 1'b0;
            next_s.cnt = '0;
          end else if (ana_in.low_cur) begin
            next_s.cnt = s.cnt + 1'b1;
            if (s.cnt == CNT_W'(DROPOUT_CYC - 1)) begin
              next_s.st = CH_IDLE;
              next_s.o.pwr = 1'b0;
              next_s.o.pg = 1'b0;
              next_s.o.disc = 1'b1;
              next_s.cnt = '0;
            end
          end else begin
            next_s.cnt = '0;
          end
        end
        CH_COOL: begin
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt == CNT_W'(COOL_CYC - 1)) begin
            next_s.st = CH_IDLE;
            next_s.cnt = '0;
          end
        end
        default: next_s.st = CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s <= '0;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

  assign out_out = s.o;
endmodule

// ==== tb/meas_model.sv ====
/*
  stand-in for the analog measurement engine: answers each start pulse
  a few cycles later with a done pulse and a detection result.
  assumes start pulses from the mode control block on the same clock.
*/
`timescale 1ns/1ns
module meas_model (
  input  wire logic       clk_in,        // system clock
  input  wire logic       sys_rst_in,    // async reset, high
  input  wire logic [3:0] start_in,      // detect or class start
  input  wire logic [3:0] valid_mask_in, // result to report
  output logic      [3:0] done_out,      // finished pulse
  output logic      [3:0] valid_out      // detection valid
);
  logic [3:0] busy;
  logic [2:0] cnt [4];
  logic       tog;
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy <= 4'h0;
      done_out <= 4'h0;
      tog <= 1'b0;
    end else begin
      tog <= ~tog;
      for (int i = 0; i < 4; i++) begin
        done_out[i] <= busy[i] && cnt[i] == 3'h0;
        if (start_in[i]) begin
          busy[i] <= 1'b1;
          cnt[i] <= 3'h5;
        end else if (busy[i] && cnt[i] == 3'h0) begin
          busy[i] <= 1'b0;
        end else if (busy[i]) begin
          cnt[i] <= cnt[i] - 3'h1;
        end
      end
    end
  end
  // outside the done pulse the result line carries noise, not the last value
  assign valid_out = (done_out & valid_mask_in) | (~done_out & {4{tog}});
endmodule

// ==== tb/tb_top.sv ====
/*
  self-checking bench for the channel mode control block.
  assumes the measurement model answers start pulses on the same clock.
*/
`timescale 1ns/1ns
module tb_top;
  import pse_mode_pkg::*;
  logic        clk_in, sys_rst_in, ce_in, reg_wr_in, reg_rd_in;
  logic        rd_d = 1'b0;
  logic [7:0]  reg_cmd_in, reg_wdata_in, reg_rdata_out, d;
  logic [3:0]  meas_done_in, det_valid_in, pg_pin_in, vmask, low_cur_pin_in, cut_fault_in;
  logic [3:0]  det_start_out, cls_start_out, power_en_out, clear_meas_out, foldback_out;
  logic [1:0]  conn_start_out;
  logic [31:0] police2_out;
  logic [15:0] police4_out, n;
  logic [15:0] exp_q[$];
  int          errors = 0, cmp_count = 0, cyc = 0, dets = 0;

  pse_mode_ctrl #(.DROPOUT_CYC(20), .COOL_CYC(50)) uut (.clk_in, .sys_rst_in, .ce_in,
    .reg_wr_in, .reg_rd_in, .reg_cmd_in, .reg_wdata_in, .reg_rdata_out, .meas_done_in,
    .det_valid_in, .pg_pin_in, .low_cur_pin_in, .cut_fault_in,
    .start_fault_in(4'h0), .ilim_fault_in(4'h0), .det_start_out, .cls_start_out,
    .conn_start_out, .power_en_out, .clear_meas_out, .police2_out, .police4_out,
    .foldback_out);
  meas_model mdl (.clk_in, .sys_rst_in, .start_in(det_start_out | cls_start_out),
    .valid_mask_in(vmask), .done_out(meas_done_in), .valid_out(det_valid_in));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    @(posedge clk_in) #1;
    reg_wr_in = 1'b1;
    reg_cmd_in = c;
    reg_wdata_in = v;
    @(posedge clk_in) #1;
    reg_wr_in = 1'b0;
  endtask
  // expected read data is queued with its command; the monitor pops it
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    @(posedge clk_in) #1;
    reg_rd_in = 1'b1;
    reg_cmd_in = c;
    exp_q.push_back({c, e});
    @(posedge clk_in) #1;
    reg_rd_in = 1'b0;
  endtask
  always @(posedge clk_in) begin
    if (rd_d) begin
      n = exp_q.pop_front();
      chk($sformatf("reg %h", n[15:8]), n[7:0], reg_rdata_out);
    end
    rd_d <= reg_rd_in & ce_in;
    dets = dets + (det_start_out[0] === 1'b1);
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_in = 1'b1;
    {ce_in, reg_wr_in, reg_rd_in} = 3'h4;
    {reg_cmd_in, reg_wdata_in, pg_pin_in, vmask, low_cur_pin_in, cut_fault_in} = 32'h0;
    void'($urandom(39));
    repeat (5) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    rd(CMD_MODE, MODE_RESET);
    rd(CMD_POL2, POLICE_RESET);
    rd(CMD_ENABLE, 8'h00);
    rd(8'h7f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = (8'($urandom) & 8'hfc) | 8'(i);
      wr(CMD_MODE, d);
      rd(CMD_MODE, d);
    end
    ce_in = 1'b0;
    wr(CMD_MODE, 8'h00);
    ce_in = 1'b1;
    rd(CMD_MODE, d);
    wr(CMD_MODE, MODE_RESET);
    wr(CMD_POWER_ON_COMMAND, 8'h0f);
    rd(CMD_STATUS, 8'h00);
    pg_pin_in = 4'h3;
    wr(CMD_MODE, 8'h55);
    wr(CMD_POL2, 8'h12);
    wr(CMD_POL2 + 8'h1, 8'h34);
    wr(CMD_FB, 8'h03);
    wr(CMD_POWER_ON_COMMAND, 8'h03);
    @(posedge clk_in) #1;
    chk("power", 8'h03, {4'h0, power_en_out});
    repeat (10) @(posedge clk_in);
    rd(CMD_STATUS, 8'h33);
    wr(CMD_MODE, 8'h54);
    repeat (10) @(posedge clk_in);
    rd(CMD_STATUS, 8'h22);
    rd(CMD_POL2, POLICE_RESET);
    rd(CMD_POL2 + 8'h1, 8'h34);
    rd(CMD_FB, 8'h02);
    chk("fold", 8'h02, {4'h0, foldback_out});
    chk("police", 8'hff, police2_out[7:0] & police4_out[15:8]);
    rd(CMD_EVENT, 8'h11);
    wr(CMD_FPW, 8'h02);
    wr(CMD_MODE, 8'h94);
    wr(CMD_POWER_ON_COMMAND, 8'h04);
    @(posedge clk_in) #1;
    chk("power", 8'h02, {4'h0, power_en_out});
    wr(CMD_MODE, 8'h54);
    wr(CMD_POWER_ON_COMMAND, 8'h04);
    @(posedge clk_in) #1;
    chk("power", 8'h06, {4'h0, power_en_out});
    vmask = 4'h1;
    wr(CMD_MODE, 8'h55);
    wr(CMD_ENABLE, 8'h01);
    repeat (20) @(posedge clk_in);
    rd(CMD_ENABLE, 8'h00);
    rd(CMD_DETCLS, 8'h01);
    wr(CMD_MODE, 8'h56);
    dets = 0;
    wr(CMD_ENABLE, 8'h01);
    repeat (40) @(posedge clk_in);
    chk("cycling", 8'h01, {7'h0, dets >= 2});
    rd(CMD_ENABLE, 8'h01);
    wr(CMD_ENABLE, 8'h10);
    repeat (10) @(posedge clk_in);
    dets = 0;
    repeat (30) @(posedge clk_in);
    chk("idle det", 8'h00, 8'(dets));
    // wiring programmed before discovery is enabled in auto
    wr(CMD_FPW, 8'h02);
    wr(CMD_MODE, 8'h57);
    wr(CMD_ENABLE, 8'h11);
    repeat (30) @(posedge clk_in);
    rd(CMD_STATUS, 8'h37);
    low_cur_pin_in = 4'h2;
    repeat (40) @(posedge clk_in);
    rd(CMD_FAULT, 8'h20);
    rd(CMD_EVENT, 8'h33);
    cut_fault_in = 4'h4;
    @(posedge clk_in) #1;
    cut_fault_in = 4'h0;
    repeat (5) @(posedge clk_in);
    rd(CMD_STATUS, 8'h11);
    rd(CMD_FAULT, 8'h24);
    rd(CMD_EVENT, 8'h37);
    wr(CMD_MODE, 8'h47);
    repeat (5) @(posedge clk_in);
    rd(CMD_FAULT, 8'h20);
    finish_test();
  end
endmodule
